/* ispi_regs.svh */
// Constants for the host pin interface: strap codes, boot access, timing
`ifndef ISPI_REGS_SVH
`define ISPI_REGS_SVH

// Two-wire slave addresses chosen by the address strap
`define ISPI_SLV_ADDR_LO 8'h90
`define ISPI_SLV_ADDR_HI 8'hba

// Boot memory access: read command, start address, blank-memory word
`define ISPI_SPI_READ_CMD 8'h03
`define ISPI_BOOT_ADDR 24'h000000
`define ISPI_BOOT_BLANK 16'hffff
`define ISPI_CFG_DEFAULT 16'h0000
`define ISPI_CFG_SMPTE_BIT 0

// System clock rate and derived cycle counts
`define ISPI_CLK_MHZ 200
`define ISPI_STRAP_SETTLE_NS 100
`define ISPI_STRAP_SETTLE_CYC \
  ((`ISPI_STRAP_SETTLE_NS * `ISPI_CLK_MHZ + 999) / 1000)
`define ISPI_MCLK_TIMEOUT_NS 10000
`define ISPI_MCLK_TIMEOUT_CYC \
  (`ISPI_MCLK_TIMEOUT_NS * `ISPI_CLK_MHZ / 1000)

// Master clock nominal rate; heartbeat toggles every 2**bits master cycles
`define ISPI_MCLK_NOMINAL_MHZ 27
`define ISPI_HEARTBEAT_BITS 4

// General-purpose pins are indexed 0..4 for pins 1..5
`define ISPI_GPIO_EXT_LSB 1

`endif

/* ispi_pkg.sv */
// Types shared by the host pin interface modules
`default_nettype none

package ispi_pkg;

  typedef enum logic [1:0] {
    BST_STRAP,
    BST_BOOT,
    BST_WAIT,
    BST_RUN
  } ispi_boot_t;

  typedef enum logic {
    SPS_IDLE,
    SPS_XFER
  } ispi_spi_st_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic cs_n;
  } ispi_spi_t;

  typedef struct packed {
    logic fv;
    logic lv;
    logic [19:0] data;
  } ispi_video_t;

endpackage

`default_nettype wire

/* ispi_sync2.sv */
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none

module ispi_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= d_i[gi];
          sync_q <= meta_q;
        end
      end
      assign q_o[gi] = sync_q;
    end
  endgenerate

endmodule // ispi_sync2

`default_nettype wire

/* ispi_spi_rd.sv */
// Boot memory SPI read engine: read command, address, one data word
`timescale 1ns/10ps
`default_nettype none
`include "ispi_regs.svh"

module ispi_spi_rd
  import ispi_pkg::*;
#(
  parameter int HALF = 4,
  parameter int RD_BITS = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic miso_i,
  output var ispi_spi_t pins_o,
  output logic [RD_BITS-1:0] rdata_o,
  output logic done_o
);

  localparam int TX_BITS = 32;
  localparam int ALL_BITS = TX_BITS + RD_BITS;
  localparam int PW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam int BW = $clog2(ALL_BITS);
  localparam logic [PW-1:0] PH_LAST = PW'(HALF - 1);
  localparam logic [BW-1:0] BIT_LAST = BW'(ALL_BITS - 1);

  ispi_spi_st_t st_q;
  logic [PW-1:0] ph_q;
  logic [BW-1:0] bit_q;
  logic [TX_BITS-1:0] sh_q;
  logic sck_q;
  logic cs_n_q;

  // Mode 0: data out moves on the falling edge, data in taken on the rising.
  // miso_i is a synchronised copy two clocks late, so HALF must exceed that.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= SPS_IDLE;
      ph_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      rdata_o <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (st_q)
        SPS_IDLE: begin
          if (start_i) begin
            st_q <= SPS_XFER;
            cs_n_q <= 1'b0;
            sh_q <= {`ISPI_SPI_READ_CMD, `ISPI_BOOT_ADDR};
            bit_q <= '0;
            ph_q <= '0;
          end
        end
        SPS_XFER: begin
          if (ph_q == PH_LAST) begin
            ph_q <= '0;
            if (!sck_q) begin
              sck_q <= 1'b1;
              rdata_o <= {rdata_o[RD_BITS-2:0], miso_i};
            end else begin
              sck_q <= 1'b0;
              sh_q <= {sh_q[TX_BITS-2:0], 1'b0};
              if (bit_q == BIT_LAST) begin
                cs_n_q <= 1'b1;
                done_o <= 1'b1;
                st_q <= SPS_IDLE;
              end else begin
                bit_q <= bit_q + 1'b1;
              end
            end
          end else begin
            ph_q <= ph_q + 1'b1;
          end
        end
        default: st_q <= SPS_IDLE;
      endcase
    end
  end

  assign pins_o = {sck_q, sh_q[TX_BITS-1], cs_n_q};

endmodule // ispi_spi_rd

`default_nettype wire

/* ispi_top.sv */
// Host pin interface: reset, standby, straps, boot SPI, host video port
`timescale 1ns/10ps
`default_nettype none
`include "ispi_regs.svh"

module ispi_top
  import ispi_pkg::*;
#(
  parameter int PCLK_DIV = 4,
  parameter int H_ACTIVE = 64,
  parameter int H_TOTAL = 80,
  parameter int V_ACTIVE = 8,
  parameter int V_TOTAL = 10,
  parameter int SPI_HALF = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic master_clock_in_i,
  input wire logic osc_bypass_i,
  output logic crystal_drive_out_o,
  input wire logic standby_i,
  input wire logic slave_address_strap_i,
  input wire logic frame_sync_i,
  input wire logic smpte_mode_i,
  input wire logic boot_memory_data_in_i,
  output logic boot_memory_data_out_o,
  output logic boot_memory_clock_o,
  output logic boot_memory_select_n_o,
  output logic host_pixel_clock_o,
  output logic host_frame_valid_o,
  output logic host_line_valid_o,
  output logic [15:0] host_data_o,
  input wire logic [4:0] gpio_i,
  output logic [4:0] gpio_o,
  output logic [4:0] gpio_oe_o,
  output logic [4:0] gpio_level_o,
  output logic [7:0] slave_address_o,
  output logic host_config_mode_o,
  output logic config_done_o,
  output logic master_clock_ok_o
);

  localparam int HALF_DIV = PCLK_DIV / 2;
  localparam int DW = (PCLK_DIV > 2) ? $clog2(PCLK_DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(PCLK_DIV - 1);
  localparam logic [DW-1:0] DIV_HALF = DW'(HALF_DIV);
  localparam logic [15:0] H_ACT = 16'(H_ACTIVE);
  localparam logic [15:0] H_LAST = 16'(H_TOTAL - 1);
  localparam logic [15:0] V_ACT = 16'(V_ACTIVE);
  localparam logic [15:0] V_LAST = 16'(V_TOTAL - 1);
  localparam logic [7:0] SETTLE = 8'(`ISPI_STRAP_SETTLE_CYC);
  localparam logic [11:0] WD_LIMIT = 12'(`ISPI_MCLK_TIMEOUT_CYC);
  localparam int HBW = `ISPI_HEARTBEAT_BITS;

  // ---------------- reset release per domain ----------------
  logic sys_rstn;
  logic mclk_rstn;

  // Reset pin acts at once; release is retimed into each domain
  ispi_sync2 #(.W(1)) u_rst_sys (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(1'b1),
    .q_o(sys_rstn)
  );

  ispi_sync2 #(.W(1)) u_rst_mclk (
    .clk_i(master_clock_in_i),
    .rstn_i(rstn_i),
    .d_i(1'b1),
    .q_o(mclk_rstn)
  );

  // ---------------- master clock domain ----------------
  logic fs_s;
  logic fs_prev_q;
  logic fs_tgl_q;
  logic [HBW-1:0] hb_cnt_q;
  logic hb_tgl_q;

  // Crystal drive only in crystal mode; left quiet with an oscillator
  assign crystal_drive_out_o = !osc_bypass_i && !master_clock_in_i;

  ispi_sync2 #(.W(1)) u_sync_mclk (
    .clk_i(master_clock_in_i),
    .rstn_i(mclk_rstn),
    .d_i(frame_sync_i),
    .q_o(fs_s)
  );

  // Frame sync rising edge becomes a toggle for the system domain
  always_ff @(posedge master_clock_in_i or negedge mclk_rstn) begin
    if (!mclk_rstn) begin
      fs_prev_q <= 1'b0;
      fs_tgl_q <= 1'b0;
    end else begin
      fs_prev_q <= fs_s;
      if (fs_s && !fs_prev_q) begin
        fs_tgl_q <= !fs_tgl_q;
      end
    end
  end

  // Heartbeat lets the system side see that the master clock runs
  always_ff @(posedge master_clock_in_i or negedge mclk_rstn) begin
    if (!mclk_rstn) begin
      hb_cnt_q <= '0;
      hb_tgl_q <= 1'b0;
    end else begin
      hb_cnt_q <= hb_cnt_q + 1'b1;
      if (&hb_cnt_q) begin
        hb_tgl_q <= !hb_tgl_q;
      end
    end
  end

  // ---------------- pin synchronisers, system domain ----------------
  logic [9:0] pin_s;
  logic standby_s;
  logic addr_s;
  logic sdi_s;
  logic fs_tgl_s;
  logic hb_tgl_s;

  ispi_sync2 #(.W(10)) u_sync_sys (
    .clk_i(clk_i),
    .rstn_i(sys_rstn),
    .d_i({hb_tgl_q, fs_tgl_q, standby_i, slave_address_strap_i,
          boot_memory_data_in_i, gpio_i}),
    .q_o(pin_s)
  );

  assign hb_tgl_s = pin_s[9];
  assign fs_tgl_s = pin_s[8];
  assign standby_s = pin_s[7];
  assign addr_s = pin_s[6];
  assign sdi_s = pin_s[5];
  assign gpio_level_o = pin_s[4:0];

  // ---------------- crossing events ----------------
  logic fs_seen_q;
  logic hb_seen_q;
  logic fsync_evt;
  logic hb_evt;
  logic [11:0] wd_q;

  assign fsync_evt = fs_tgl_s ^ fs_seen_q;
  assign hb_evt = hb_tgl_s ^ hb_seen_q;

  always_ff @(posedge clk_i or negedge sys_rstn) begin
    if (!sys_rstn) begin
      fs_seen_q <= 1'b0;
      hb_seen_q <= 1'b0;
    end else begin
      fs_seen_q <= fs_tgl_s;
      hb_seen_q <= hb_tgl_s;
    end
  end

  // Master clock watchdog: no heartbeat for the timeout means clock lost
  always_ff @(posedge clk_i or negedge sys_rstn) begin
    if (!sys_rstn) begin
      wd_q <= WD_LIMIT;
    end else if (hb_evt) begin
      wd_q <= '0;
    end else if (wd_q != WD_LIMIT) begin
      wd_q <= wd_q + 1'b1;
    end
  end

  assign master_clock_ok_o = (wd_q != WD_LIMIT);

  // ---------------- straps and boot configuration ----------------
  ispi_boot_t bst_q;
  logic [7:0] settle_q;
  logic strap_q;
  logic host_cfg_q;
  logic [15:0] cfg_word_q;
  logic spi_start;
  logic spi_done;
  logic [15:0] spi_rdata;
  ispi_spi_t spi_pins;

  assign spi_start = (bst_q == BST_BOOT) && !standby_s;

  // Straps are read once, after they have settled past the reset release
  always_ff @(posedge clk_i or negedge sys_rstn) begin
    if (!sys_rstn) begin
      bst_q <= BST_STRAP;
      settle_q <= SETTLE;
      strap_q <= 1'b0;
      host_cfg_q <= 1'b0;
      cfg_word_q <= `ISPI_CFG_DEFAULT;
    end else begin
      case (bst_q)
        BST_STRAP: begin
          if (settle_q != 8'h00) begin
            settle_q <= settle_q - 1'b1;
          end else begin
            strap_q <= addr_s;
            host_cfg_q <= !sdi_s;
            bst_q <= sdi_s ? BST_BOOT : BST_RUN;
          end
        end
        BST_BOOT: begin
          if (spi_start) begin
            bst_q <= BST_WAIT;
          end
        end
        BST_WAIT: begin
          if (spi_done) begin
            // An all-ones word is the pull-up: no memory fitted
            cfg_word_q <= (spi_rdata == `ISPI_BOOT_BLANK) ?
                          `ISPI_CFG_DEFAULT : spi_rdata;
            bst_q <= BST_RUN;
          end
        end
        BST_RUN: bst_q <= BST_RUN;
        default: bst_q <= BST_STRAP;
      endcase
    end
  end

  assign slave_address_o = strap_q ? `ISPI_SLV_ADDR_HI :
                           `ISPI_SLV_ADDR_LO;
  assign host_config_mode_o = host_cfg_q;
  assign config_done_o = (bst_q == BST_RUN);

  ispi_spi_rd #(.HALF(SPI_HALF), .RD_BITS(16)) u_spi (
    .clk_i(clk_i),
    .rstn_i(sys_rstn),
    .start_i(spi_start),
    .miso_i(sdi_s),
    .pins_o(spi_pins),
    .rdata_o(spi_rdata),
    .done_o(spi_done)
  );

  assign boot_memory_clock_o = spi_pins.sck;
  assign boot_memory_data_out_o = spi_pins.mosi;
  assign boot_memory_select_n_o = spi_pins.cs_n;

  // ---------------- host pixel clock ----------------
  logic vid_en;
  logic [DW-1:0] div_q;
  logic pclk_q;
  logic launch;

  assign vid_en = (bst_q == BST_RUN) && !standby_s;
  // Launch on the falling pixel clock edge, so the host has half a period
  assign launch = vid_en && (div_q == DIV_HALF);

  always_ff @(posedge clk_i or negedge sys_rstn) begin
    if (!sys_rstn) begin
      div_q <= '0;
      pclk_q <= 1'b0;
    end else if (!vid_en) begin
      div_q <= '0;
      pclk_q <= 1'b0;
    end else begin
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
      pclk_q <= (div_q < DIV_HALF);
    end
  end

  assign host_pixel_clock_o = pclk_q;

  // ---------------- frame timing and output data ----------------
  logic [15:0] hcnt_q;
  logic [15:0] vcnt_q;
  logic fs_pend_q;
  logic smpte_q;
  logic [19:0] pix_q;
  ispi_video_t vid_q;
  logic fv_now;
  logic lv_now;
  logic frame_start;

  assign fv_now = (vcnt_q < V_ACT);
  assign lv_now = fv_now && (hcnt_q < H_ACT);
  assign frame_start = (hcnt_q == 16'h0000) && (vcnt_q == 16'h0000);

  // A sync seen mid-pixel waits for the next launch; set beats clear
  always_ff @(posedge clk_i or negedge sys_rstn) begin
    if (!sys_rstn) begin
      fs_pend_q <= 1'b0;
    end else begin
      fs_pend_q <= fsync_evt || (fs_pend_q && !launch);
    end
  end

  always_ff @(posedge clk_i or negedge sys_rstn) begin
    if (!sys_rstn) begin
      hcnt_q <= '0;
      vcnt_q <= '0;
    end else if (!vid_en) begin
      hcnt_q <= '0;
      vcnt_q <= '0;
    end else if (launch) begin
      if (fs_pend_q) begin
        hcnt_q <= '0;
        vcnt_q <= '0;
      end else if (hcnt_q == H_LAST) begin
        hcnt_q <= '0;
        vcnt_q <= (vcnt_q == V_LAST) ? '0 : vcnt_q + 1'b1;
      end else begin
        hcnt_q <= hcnt_q + 1'b1;
      end
    end
  end

  // Width changes only at a frame boundary, never inside a frame
  always_ff @(posedge clk_i or negedge sys_rstn) begin
    if (!sys_rstn) begin
      smpte_q <= 1'b0;
    end else if (launch && frame_start) begin
      smpte_q <= host_cfg_q ? smpte_mode_i :
                 cfg_word_q[`ISPI_CFG_SMPTE_BIT];
    end
  end

  // Ramp test pattern, restarted every frame
  always_ff @(posedge clk_i or negedge sys_rstn) begin
    if (!sys_rstn) begin
      pix_q <= '0;
    end else if (!vid_en) begin
      pix_q <= '0;
    end else if (launch) begin
      pix_q <= frame_start ? 20'h00001 : (lv_now ? pix_q + 1'b1 : pix_q);
    end
  end

  always_ff @(posedge clk_i or negedge sys_rstn) begin
    if (!sys_rstn) begin
      vid_q <= '0;
    end else if (!vid_en) begin
      vid_q <= '0;
    end else if (launch) begin
      vid_q.fv <= fv_now;
      vid_q.lv <= lv_now;
      vid_q.data <= lv_now ? (frame_start ? 20'h00000 : pix_q) : '0;
    end
  end

  assign host_frame_valid_o = vid_q.fv;
  assign host_line_valid_o = vid_q.lv;
  assign host_data_o = vid_q.data[15:0];
  // Pin 1 stays an input; pins 5..2 carry the upper bits in SMPTE mode
  assign gpio_o = {vid_q.data[19:16], 1'b0};
  assign gpio_oe_o = {{4{smpte_q && vid_en}}, 1'b0};

  // ---------------- checks ----------------
  logic seen_q;

  always_ff @(posedge clk_i or negedge sys_rstn) begin
    if (!sys_rstn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!sys_rstn);

  AST_RESET_IDLE: assert property (
    !seen_q |-> !vid_q.fv && spi_pins.cs_n && !pclk_q && bst_q == BST_STRAP)
    else $error("outputs not idle after reset release");

  AST_STANDBY_STOP: assert property (
    standby_s |=> !pclk_q && !vid_q.fv && !vid_q.lv)
    else $error("video active during standby");

  AST_SLAVE_ADDR: assert property (
    bst_q == BST_STRAP && settle_q == 8'h00 |=>
      slave_address_o == ($past(addr_s) ? 8'hba : 8'h90))
    else $error("slave address does not follow strap");

  AST_CFG_MODE: assert property (
    bst_q == BST_STRAP && settle_q == 8'h00 && !sdi_s |=>
      host_cfg_q && bst_q == BST_RUN && spi_pins.cs_n)
    else $error("host config strap not honoured");

  AST_FSYNC_ALIGN: assert property (
    launch && fs_pend_q |=> hcnt_q == 16'h0000 && vcnt_q == 16'h0000)
    else $error("frame sync did not restart timing");

  AST_FV_EDGE: assert property (
    $changed(vid_q.fv) && vid_en |-> $past(launch) && !pclk_q)
    else $error("frame valid moved off the falling clock edge");

  AST_LV_IN_FV: assert property (
    $changed(vid_q.lv) && vid_en |-> $past(launch) && (!vid_q.lv || vid_q.fv))
    else $error("line valid off edge or outside frame");

  AST_DATA_EDGE: assert property (
    $changed(vid_q.data) && vid_en |-> $past(launch) && !pclk_q)
    else $error("data moved off the falling clock edge");

  AST_SMPTE_PINS: assert property (
    !vid_en |=> gpio_o == 5'h00)
    else $error("extension pins carry data while video stopped");

  AST_SMPTE_FRAME: assert property (
    $changed(smpte_q) |-> $past(frame_start) && !pclk_q)
    else $error("output width changed inside a frame");

  AST_SPI_SELECT: assert property (
    $rose(spi_pins.sck) |-> !spi_pins.cs_n ##1 !spi_pins.cs_n)
    else $error("boot clock pulsed without chip select");

  AST_MCLK_OK: assert property (
    hb_evt |=> master_clock_ok_o [*2])
    else $error("master clock heartbeat not recognised");

endmodule // ispi_top

`default_nettype wire

/* ispi_host_model.sv */
// Far-side model: boot flash on the SPI port and the host video receiver
`timescale 1ns/10ps
`default_nettype none

module ispi_host_model
  import ispi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] mode_i,
  input wire logic [15:0] word_i,
  input wire ispi_spi_t spi_i,
  output logic miso_o,
  input wire logic pclk_i,
  input wire ispi_video_t vid_i,
  input wire logic edge_chk_i,
  output logic [31:0] cmd_o,
  output var int bits_o,
  output var int pix_o,
  output var int zero_o,
  output var int bad_o,
  output var int edge_o,
  output logic [19:0] wrap_o
);
  logic drv = 1'b0;
  logic bitv = 1'b1;
  logic pv_q = 1'b0;
  ispi_video_t vid_q;
  logic [19:0] last;

  // Mode 0: no memory, pin pulled up; 1: memory fitted; 2: strapped low
  assign miso_o = (mode_i == 2'd2) ? 1'b0 : (drv ? bitv : 1'b1);

  // A new select or a reset clears the count; a rising clock counts a bit
  always @(negedge rstn_i or negedge spi_i.cs_n or posedge spi_i.sck) begin
    if (!rstn_i || !spi_i.sck) begin
      bits_o = 0;
      cmd_o = '0;
    end else begin
      if (bits_o < 32)
        cmd_o = {cmd_o[30:0], spi_i.mosi};
      bits_o = bits_o + 1;
    end
  end

  // Flash drives only in the data phase; the pull-up shows elsewhere
  always @(negedge spi_i.sck or posedge spi_i.cs_n) begin
    drv <= #1 (mode_i == 2'd1) && !spi_i.cs_n && bits_o >= 32 && bits_o < 48;
    if (bits_o >= 32 && bits_o < 48)
      bitv <= #1 word_i[47 - bits_o];
  end

  always @(posedge pclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pix_o = 0;
      zero_o = 0;
      bad_o = 0;
      last = '0;
      wrap_o = '0;
    end else if (vid_i.fv && vid_i.lv) begin
      pix_o = pix_o + 1;
      if (vid_i.data == 20'h00000) begin
        zero_o = zero_o + 1;
        wrap_o = last;
      end else if (vid_i.data != last + 20'h00001) begin
        bad_o = bad_o + 1;
      end
      last = vid_i.data;
    end
  end

  // Any output change must come with a falling pixel clock
  always @(posedge clk_i) begin
    if (!rstn_i)
      edge_o = 0;
    else if (edge_chk_i && vid_i != vid_q && !(pv_q && !pclk_i))
      edge_o = edge_o + 1;
    vid_q = vid_i;
    pv_q = pclk_i;
  end
endmodule  // ispi_host_model

`default_nettype wire

/* ispi_tb.sv */
// Self-checking bench for the host pin interface
`timescale 1ns/10ps
`default_nettype none
`include "ispi_regs.svh"

module testbench;
  localparam int HA = 8;
  localparam int VA = 2;
  logic clk_i = 1'b0;
  logic mclk = 1'b0;
  logic rstn_i = 1'b0;
  logic osc_bypass = 1'b1;
  logic standby = 1'b0;
  logic addr_strap = 1'b0;
  logic frame_sync = 1'b0;
  logic smpte = 1'b0;
  logic [4:0] gpio_in = 5'h00;
  logic [1:0] mem_mode = 2'd0;
  logic [15:0] mem_word = 16'hffff;
  logic edge_chk = 1'b0;
  logic miso, xdrv, mosi, sck, cs_n, pclk, fv, lv, cfg_host, cfg_done, mck_ok;
  logic [15:0] hdata;
  logic [4:0] gpio_o, gpio_oe, gpio_lvl;
  logic [7:0] slv_addr;
  logic [31:0] cmd;
  logic [19:0] wrap;
  int bits, pix, zeros, bad, edges;
  int err_count = 0;
  int compares = 0;

  always #2.5 clk_i = ~clk_i;
  // Offset keeps the master clock out of step with the system clock
  initial begin
    #1.3;
    forever #80 mclk = ~mclk;
  end

  ispi_top #(.PCLK_DIV(4), .H_ACTIVE(HA), .H_TOTAL(10), .V_ACTIVE(VA),
    .V_TOTAL(4), .SPI_HALF(4)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .master_clock_in_i(mclk),
    .osc_bypass_i(osc_bypass), .crystal_drive_out_o(xdrv),
    .standby_i(standby), .slave_address_strap_i(addr_strap),
    .frame_sync_i(frame_sync), .smpte_mode_i(smpte),
    .boot_memory_data_in_i(miso), .boot_memory_data_out_o(mosi),
    .boot_memory_clock_o(sck), .boot_memory_select_n_o(cs_n),
    .host_pixel_clock_o(pclk), .host_frame_valid_o(fv),
    .host_line_valid_o(lv), .host_data_o(hdata), .gpio_i(gpio_in),
    .gpio_o(gpio_o), .gpio_oe_o(gpio_oe), .gpio_level_o(gpio_lvl),
    .slave_address_o(slv_addr), .host_config_mode_o(cfg_host),
    .config_done_o(cfg_done), .master_clock_ok_o(mck_ok));

  ispi_host_model far_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mem_mode), .word_i(mem_word),
    .spi_i({sck, mosi, cs_n}), .miso_o(miso), .pclk_i(pclk),
    .vid_i({fv, lv, gpio_o[4:1], hdata}), .edge_chk_i(edge_chk),
    .cmd_o(cmd), .bits_o(bits), .pix_o(pix), .zero_o(zeros), .bad_o(bad),
    .edge_o(edges), .wrap_o(wrap));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_fv();
    int n;
    n = 0;
    while (fv !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    check("fv_rise", fv, 1);
    cyc(2);
  endtask

  // Reset held long enough for three master clock edges
  task automatic boot(input logic strap, input logic [1:0] mode,
                      input logic [15:0] word);
    int n;
    cyc(1);
    rstn_i = 1'b0;
    addr_strap = strap;
    mem_mode = mode;
    mem_word = word;
    cyc(100);
    rstn_i = 1'b1;
    n = 0;
    while (cfg_done !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    check("config_done", cfg_done, 1);
  endtask

  task automatic t_reset_vals();
    check("select_n", cs_n, 1);
    check("sck", sck, 0);
    check("addr", slv_addr, 32'h90);
    check("done", cfg_done, 0);
    check("pclk", pclk, 0);
    check("gpio_oe", gpio_oe, 0);
  endtask

  task automatic t_boot_auto();
    boot(1'b0, 2'd0, 16'h0000);
    check("addr", slv_addr, 32'h90);
    check("host_cfg", cfg_host, 0);
    check("spi_cmd", cmd, {`ISPI_SPI_READ_CMD, `ISPI_BOOT_ADDR});
    check("spi_bits", bits, 48);
    check("select_n", cs_n, 1);
    wait_fv();
    check("gpio_oe", gpio_oe, 0);
  endtask

  task automatic t_video();
    edge_chk = 1'b1;
    cyc(700);
    edge_chk = 1'b0;
    check("edges", edges, 0);
    check("ramp", bad, 0);
    check("wrap", wrap, HA * VA - 1);
    check("frames", zeros >= 3, 1);
  endtask

  task automatic t_standby();
    int p0;
    int b0;
    standby = 1'b1;
    cyc(4);
    // Counts taken once the stop holds; a clock rise may land just before
    p0 = pix;
    b0 = bad;
    check("sb_pclk", pclk, 0);
    check("sb_video", {fv, lv, hdata}, 0);
    cyc(60);
    check("sb_pix", pix, p0);
    standby = 1'b0;
    cyc(400);
    check("resume", pix > p0, 1);
    check("resume_ramp", bad, b0);
  endtask

  task automatic t_sync();
    int z0;
    int n;
    z0 = zeros;
    n = 0;
    while (zeros == z0 && n < 400) begin
      cyc(1);
      n++;
    end
    check("frame_seen", n < 400, 1);
    z0 = zeros;
    frame_sync = 1'b1;
    cyc(70);
    frame_sync = 1'b0;
    cyc(70);
    check("sync_restart", zeros, z0 + 1);
  endtask

  task automatic t_misc();
    check("mclk_ok", mck_ok, 1);
    osc_bypass = 1'b0;
    gpio_in = 5'h15;
    @(posedge mclk);
    #1;
    check("xdrv_hi", xdrv, 0);
    @(negedge mclk);
    #1;
    check("xdrv_lo", xdrv, 1);
    cyc(1);
    osc_bypass = 1'b1;
    cyc(2);
    check("xdrv_off", xdrv, 0);
    check("gpio_lvl", gpio_lvl, 32'h15);
  endtask

  task automatic t_boot_mem();
    boot(1'b1, 2'd1, 16'h0001);
    check("addr", slv_addr, 32'hba);
    check("host_cfg", cfg_host, 0);
    check("spi_bits", bits, 48);
    wait_fv();
    check("gpio_oe", gpio_oe, 32'h1e);
  endtask

  task automatic t_host_cfg();
    smpte = 1'b1;
    boot(1'b0, 2'd2, 16'h0000);
    check("host_cfg", cfg_host, 1);
    check("spi_bits", bits, 0);
    wait_fv();
    check("gpio_oe", gpio_oe, 32'h1e);
    check("gpio_pin1", gpio_oe[0], 0);
    smpte = 1'b0;
  endtask

  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end

  initial begin
    cyc(4);
    t_reset_vals();
    cyc(4);
    rstn_i = 1'b1;
    t_boot_auto();
    t_video();
    t_standby();
    t_sync();
    t_misc();
    t_boot_mem();
    t_host_cfg();
    report_and_stop();
  end
endmodule  // testbench

`default_nettype wire
